// file: pkg/cmp_pkg.sv
// shared constants for the dual comparator digital block
// assumes an 8-bit register port with one-cycle read latency
package cmp_pkg;
    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;
    // register index map
    localparam logic [2:0] CTRL1_ADDR = 3'h0;
    localparam logic [2:0] CTRL2_ADDR = 3'h1;
    localparam logic [2:0] STATUS_ADDR = 3'h2;
    localparam logic [2:0] LADDER_ADDR = 3'h3;
    localparam logic [2:0] FLAGS_ADDR = 3'h4;
    localparam logic [2:0] ENABLES_ADDR = 3'h5;
    localparam logic [2:0] PRIORITY_ADDR = 3'h6;
    localparam logic [2:0] CORE_ADDR = 3'h7;
    // comparator control fields
    localparam int ON_BIT = 7;
    localparam int PIN_EN_BIT = 6;
    localparam int INVERT_BIT = 5;
    localparam int EDGE_HI = 4;
    localparam int EDGE_LO = 3;
    // ladder control fields
    localparam int LADDER_RANGE_BIT = 5;
    localparam int LADDER_SOURCE_BIT = 4;
    // flag / enable / core fields
    localparam int CMP2_FLAG_BIT = 6;
    localparam int CMP1_FLAG_BIT = 5;
    localparam int PERIPH_EN_BIT = 6;
    localparam int GLOBAL_EN_BIT = 7;
    // reset values and edge-select codes
    localparam logic [7:0] CTRL_RESET = 8'h1F;
    localparam logic [7:0] ZERO_RESET = 8'h00;
    localparam logic [1:0] EDGE_NONE = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_ANY = 2'h3;
    // level of a disabled comparator's raw output
    localparam logic DISABLED_RAW = 1'b0;
endpackage

// file: design/comparator_output_interrupt.sv
// digital side of a dual comparator: polarity, status, pin steering, edge flags
// assumes raw comparator outputs are asynchronous; register port on ref_clk
//
// Local design decisions: the plain strobed port and the register addresses.
`timescale 1ns/1ps
module comparator_output_interrupt
    import cmp_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic clk_en,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [DATA_W-1:0] rdata,
    input wire logic [1:0] raw_result,
    input wire logic sleeping,
    output logic [1:0] remappable_pin,
    output logic [1:0] remappable_pin_sel,
    output logic [1:0] comparator_on,
    output logic ladder_on,
    output logic ladder_pin_enable,
    output logic ladder_range_select,
    output logic ladder_source_select,
    output logic [3:0] ladder_level,
    output logic irq,
    output logic wake
);

    ////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [1:0][7:0] comparator_control;
        logic [7:0] reference_ladder_control;
        logic [7:0] peripheral_flags_two;
        logic [7:0] peripheral_enables_two;
        logic [7:0] peripheral_priority_two;
        logic [7:0] interrupt_core_control;
        logic [1:0] sync1;
        logic [1:0] sync2;
        logic [1:0] adjusted;
        logic [7:0] rdata;
        logic [1:0] pin;
        logic [1:0] pin_sel;
        logic irq;
        logic wake;
    } state_t;

    state_t st;
    state_t next_st;

    logic [1:0] adj_now;
    logic [1:0] rise;
    logic [1:0] fall;
    logic [1:0] edge_hit;
    logic [1:0] any_written;
    logic [1:0] req;

    ////////////////////////////////////////////////////////////////////////
    // per-comparator result and edge qualification
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_cmp
            logic [1:0] sel;
            logic on;
            assign sel = st.comparator_control[g][EDGE_HI:EDGE_LO];
            assign on = st.comparator_control[g][ON_BIT];
            // disabled comparator forced to DISABLED_RAW, so no edges after the cycle it is switched off
            assign adj_now[g] = on
                ? (st.sync2[g] ^ st.comparator_control[g][INVERT_BIT])
                : DISABLED_RAW;
            assign rise[g] = adj_now[g] & ~st.adjusted[g];
            assign fall[g] = ~adj_now[g] & st.adjusted[g];
            always_comb begin
                unique case (sel)
                    EDGE_NONE: edge_hit[g] = 1'b0;
                    EDGE_RISE: edge_hit[g] = rise[g];
                    EDGE_FALL: edge_hit[g] = fall[g];
                    EDGE_ANY: edge_hit[g] = rise[g] | fall[g];
                endcase
            end
            // selecting any-change raises the flag at once
            assign any_written[g] = wr && addr == (g == 0 ? CTRL1_ADDR : CTRL2_ADDR)
                && wdata[EDGE_HI:EDGE_LO] == EDGE_ANY;
        end
    endgenerate

    assign req[0] = st.peripheral_flags_two[CMP1_FLAG_BIT]
        & st.peripheral_enables_two[CMP1_FLAG_BIT];
    assign req[1] = st.peripheral_flags_two[CMP2_FLAG_BIT]
        & st.peripheral_enables_two[CMP2_FLAG_BIT];

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_st = st;
        next_st.sync1 = raw_result;
        next_st.sync2 = st.sync1;
        next_st.adjusted = adj_now;
        // register writes; control state ignores sleep entirely
        if (wr) begin
            unique case (addr)
                CTRL1_ADDR: next_st.comparator_control[0] = wdata;
                CTRL2_ADDR: next_st.comparator_control[1] = wdata;
                LADDER_ADDR: next_st.reference_ladder_control = wdata;
                FLAGS_ADDR: next_st.peripheral_flags_two = wdata;
                ENABLES_ADDR: next_st.peripheral_enables_two = wdata;
                PRIORITY_ADDR: next_st.peripheral_priority_two = wdata;
                CORE_ADDR: next_st.interrupt_core_control = wdata;
                default: ; // status is read-only
            endcase
        end
        // hardware set wins over a same-cycle software clear
        if (edge_hit[0] || any_written[0]) begin
            next_st.peripheral_flags_two[CMP1_FLAG_BIT] = 1'b1;
        end
        if (edge_hit[1] || any_written[1]) begin
            next_st.peripheral_flags_two[CMP2_FLAG_BIT] = 1'b1;
        end
        next_st.rdata = ZERO_RESET;
        if (rd) begin
            unique case (addr)
                CTRL1_ADDR: next_st.rdata = st.comparator_control[0];
                CTRL2_ADDR: next_st.rdata = st.comparator_control[1];
                STATUS_ADDR: next_st.rdata = {6'h00, st.adjusted};
                LADDER_ADDR: next_st.rdata = st.reference_ladder_control;
                FLAGS_ADDR: next_st.rdata = st.peripheral_flags_two;
                ENABLES_ADDR: next_st.rdata = st.peripheral_enables_two;
                PRIORITY_ADDR: next_st.rdata = st.peripheral_priority_two;
                CORE_ADDR: next_st.rdata = st.interrupt_core_control;
            endcase
        end
        for (int i = 0; i < 2; i++) begin
            next_st.pin[i] = st.adjusted[i];
            next_st.pin_sel[i] = st.comparator_control[i][PIN_EN_BIT];
        end
        // flags set regardless; delivery needs all three enables
        next_st.irq = (|req) && st.interrupt_core_control[PERIPH_EN_BIT]
            && st.interrupt_core_control[GLOBAL_EN_BIT];
        // wake needs only the local enable, the cores' gates are asleep too
        next_st.wake = sleeping && (|req);
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            st <= '0;
            st.comparator_control[0] <= CTRL_RESET;
            st.comparator_control[1] <= CTRL_RESET;
            st.reference_ladder_control <= ZERO_RESET;
        end else if (clk_en) begin
            st <= next_st;
        end
    end

    assign rdata = st.rdata;
    assign remappable_pin = st.pin;
    assign remappable_pin_sel = st.pin_sel;
    assign comparator_on = {st.comparator_control[1][ON_BIT],
                            st.comparator_control[0][ON_BIT]};
    assign ladder_on = st.reference_ladder_control[ON_BIT];
    assign ladder_pin_enable = st.reference_ladder_control[PIN_EN_BIT];
    // analog ladder uses these: range 1 gives level/24, range 0 span/4+level/32
    assign ladder_range_select = st.reference_ladder_control[LADDER_RANGE_BIT];
    assign ladder_source_select = st.reference_ladder_control[LADDER_SOURCE_BIT];
    assign ladder_level = st.reference_ladder_control[3:0];
    assign irq = st.irq;
    assign wake = st.wake;

    ////////////////////////////////////////////////////////////////////////
    status_bits_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        clk_en && rd && addr == STATUS_ADDR |=> rdata == {6'h00, $past(st.adjusted)})
        else $error("status read mismatch");
    flag_rise_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        clk_en && rise[0] && st.comparator_control[0][EDGE_HI:EDGE_LO] == EDGE_RISE
        |=> st.peripheral_flags_two[CMP1_FLAG_BIT])
        else $error("rising edge lost");
    flag_none_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        clk_en && !wr && !st.peripheral_flags_two[CMP1_FLAG_BIT]
        && st.comparator_control[0][EDGE_HI:EDGE_LO] == EDGE_NONE
        |=> !st.peripheral_flags_two[CMP1_FLAG_BIT])
        else $error("flag set with edges off");
    flag_sticky_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        clk_en && !(wr && addr == FLAGS_ADDR) && st.peripheral_flags_two[CMP2_FLAG_BIT]
        |=> st.peripheral_flags_two[CMP2_FLAG_BIT])
        else $error("flag dropped without write");
    any_mode_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        clk_en && any_written[1] |=> st.peripheral_flags_two[CMP2_FLAG_BIT])
        else $error("any-change select did not set flag");
    irq_gate_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        irq |-> $past(st.interrupt_core_control[GLOBAL_EN_BIT]))
        else $error("irq without global enable");
    disabled_quiet_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        !st.comparator_control[0][ON_BIT] |-> adj_now[0] == DISABLED_RAW)
        else $error("disabled comparator moved");
    pin_sel_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        clk_en ##1 clk_en |-> remappable_pin_sel[1]
        == $past(st.comparator_control[1][PIN_EN_BIT]))
        else $error("pin select lag wrong");

    ////////////////////////////////////////////////////////////////////////
    // register port behaviour
    status_upper_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        clk_en && rd && addr == STATUS_ADDR |=> rdata[7:2] == 6'h00)
        else $error("status upper bits not zero");
    status_write_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        clk_en && wr && addr == STATUS_ADDR |=> $stable(st.comparator_control))
        else $error("status write changed control");
    rdata_idle_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        clk_en && !rd |=> rdata == ZERO_RESET)
        else $error("read data not idle");
    flag_read_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        clk_en && rd && addr == FLAGS_ADDR |=> rdata == $past(st.peripheral_flags_two))
        else $error("flag read mismatch");
    ctrl_read_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        clk_en && rd && addr == CTRL1_ADDR |=> rdata == $past(st.comparator_control[0]))
        else $error("control read mismatch");
    ctrl_write_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        clk_en && wr && addr == CTRL2_ADDR |=> st.comparator_control[1] == $past(wdata))
        else $error("control write lost");
    prio_write_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        clk_en && wr && addr == PRIORITY_ADDR |=> st.peripheral_priority_two == $past(wdata))
        else $error("priority write lost");
    enable_write_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        clk_en && wr && addr == ENABLES_ADDR |=> st.peripheral_enables_two == $past(wdata))
        else $error("enable write lost");
    core_write_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        clk_en && wr && addr == CORE_ADDR |=> st.interrupt_core_control == $past(wdata))
        else $error("core write lost");

    ////////////////////////////////////////////////////////////////////////
    // result path
    sync_first_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        clk_en |=> st.sync1 == $past(raw_result))
        else $error("first sync stage wrong");
    sync_chain_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        clk_en |=> st.sync2 == $past(st.sync1))
        else $error("second sync stage wrong");
    invert_one_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        st.comparator_control[0][ON_BIT]
        |-> adj_now[0] == (st.sync2[0] ^ st.comparator_control[0][INVERT_BIT]))
        else $error("polarity one wrong");
    invert_two_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        st.comparator_control[1][ON_BIT]
        |-> adj_now[1] == (st.sync2[1] ^ st.comparator_control[1][INVERT_BIT]))
        else $error("polarity two wrong");
    adjusted_reg_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        clk_en |=> st.adjusted == $past(adj_now))
        else $error("adjusted result lag wrong");
    pin_follow_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        clk_en |=> remappable_pin == $past(st.adjusted))
        else $error("pin result lag wrong");
    pin_sel_one_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        clk_en |=> remappable_pin_sel[0] == $past(st.comparator_control[0][PIN_EN_BIT]))
        else $error("pin select one wrong");
    disabled_two_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        !st.comparator_control[1][ON_BIT] |-> adj_now[1] == DISABLED_RAW)
        else $error("disabled comparator two moved");
    disabled_edge_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        !st.comparator_control[0][ON_BIT] && !st.adjusted[0] |-> !rise[0] && !fall[0])
        else $error("disabled comparator made an edge");

    ////////////////////////////////////////////////////////////////////////
    // edge selection and flags
    flag_fall_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        clk_en && fall[0] && st.comparator_control[0][EDGE_HI:EDGE_LO] == EDGE_FALL
        |=> st.peripheral_flags_two[CMP1_FLAG_BIT])
        else $error("falling edge lost");
    rise_ignored_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        clk_en && !wr && !fall[0] && !st.peripheral_flags_two[CMP1_FLAG_BIT]
        && st.comparator_control[0][EDGE_HI:EDGE_LO] == EDGE_FALL
        |=> !st.peripheral_flags_two[CMP1_FLAG_BIT])
        else $error("flag set without falling edge");
    fall_ignored_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        clk_en && !wr && !rise[0] && !st.peripheral_flags_two[CMP1_FLAG_BIT]
        && st.comparator_control[0][EDGE_HI:EDGE_LO] == EDGE_RISE
        |=> !st.peripheral_flags_two[CMP1_FLAG_BIT])
        else $error("flag set without rising edge");
    any_edge_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        clk_en && (rise[0] || fall[0])
        && st.comparator_control[0][EDGE_HI:EDGE_LO] == EDGE_ANY
        |=> st.peripheral_flags_two[CMP1_FLAG_BIT])
        else $error("any-change edge lost");
    none_two_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        clk_en && !wr && !st.peripheral_flags_two[CMP2_FLAG_BIT]
        && st.comparator_control[1][EDGE_HI:EDGE_LO] == EDGE_NONE
        |=> !st.peripheral_flags_two[CMP2_FLAG_BIT])
        else $error("flag two set with edges off");
    any_decode_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        clk_en && wr && addr == CTRL1_ADDR && wdata[EDGE_HI:EDGE_LO] == EDGE_ANY
        |=> st.peripheral_flags_two[CMP1_FLAG_BIT])
        else $error("any-change write did not set flag one");
    sticky_one_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        clk_en && !(wr && addr == FLAGS_ADDR) && st.peripheral_flags_two[CMP1_FLAG_BIT]
        |=> st.peripheral_flags_two[CMP1_FLAG_BIT])
        else $error("flag one dropped without write");
    flag_clear_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        clk_en && wr && addr == FLAGS_ADDR && !wdata[CMP1_FLAG_BIT] && !edge_hit[0]
        |=> !st.peripheral_flags_two[CMP1_FLAG_BIT])
        else $error("flag one clear lost");
    soft_set_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        clk_en && wr && addr == FLAGS_ADDR && wdata[CMP2_FLAG_BIT]
        |=> st.peripheral_flags_two[CMP2_FLAG_BIT])
        else $error("software set of flag two lost");
    flag_ungated_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        clk_en && rise[1] && st.comparator_control[1][EDGE_HI:EDGE_LO] == EDGE_RISE
        |=> st.peripheral_flags_two[CMP2_FLAG_BIT])
        else $error("flag two not set by its edge");

    ////////////////////////////////////////////////////////////////////////
    // request delivery and sleep
    irq_periph_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        irq |-> $past(st.interrupt_core_control[PERIPH_EN_BIT]))
        else $error("irq without peripheral enable");
    irq_req_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        irq |-> $past(|req))
        else $error("irq without enabled flag");
    irq_on_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        clk_en && (|req) && st.interrupt_core_control[PERIPH_EN_BIT]
        && st.interrupt_core_control[GLOBAL_EN_BIT] |=> irq)
        else $error("enabled request not delivered");
    wake_on_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        clk_en && sleeping && (|req) |=> wake)
        else $error("enabled request did not wake");
    wake_off_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        clk_en && !sleeping |=> !wake)
        else $error("wake while awake");
    sleep_hold_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        clk_en && sleeping && !wr |=> $stable(st.comparator_control))
        else $error("control changed in sleep");
    ladder_hold_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        clk_en && sleeping && !wr |=> $stable(st.reference_ladder_control))
        else $error("ladder changed in sleep");

    ////////////////////////////////////////////////////////////////////////
    // reset and ladder fields
    ctrl_reset_a: assert property (@(posedge ref_clk)
        !rstn |=> st.comparator_control[0] == CTRL_RESET
        && st.comparator_control[1] == CTRL_RESET)
        else $error("control not reset");
    ladder_reset_a: assert property (@(posedge ref_clk)
        !rstn |=> st.reference_ladder_control == ZERO_RESET && !ladder_on)
        else $error("ladder not reset");
    outputs_reset_a: assert property (@(posedge ref_clk)
        !rstn |=> !irq && !wake && comparator_on == 2'h0)
        else $error("outputs not reset");
    level_write_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        clk_en && wr && addr == LADDER_ADDR |=> ladder_level == $past(wdata[3:0]))
        else $error("ladder level write lost");
    range_write_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        clk_en && wr && addr == LADDER_ADDR
        |=> ladder_range_select == $past(wdata[LADDER_RANGE_BIT]))
        else $error("ladder range write lost");
    source_write_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        clk_en && wr && addr == LADDER_ADDR
        |=> ladder_source_select == $past(wdata[LADDER_SOURCE_BIT]))
        else $error("ladder source write lost");

endmodule

// file: verification/tb_comparator_output_interrupt.sv
// self-checking bench for the dual comparator digital block
// assumes cmp_pkg and the design are compiled first; register port driven directly
`timescale 1ns/1ps
module tb_comparator_output_interrupt
    import cmp_pkg::*;
;
logic ref_clk = 1'b0;
logic rstn = 1'b0;
logic clk_en = 1'b1;
logic wr = 1'b0;
logic rd = 1'b0;
logic sleeping = 1'b0;
logic [2:0] addr = 3'h0;
logic [7:0] wdata = 8'h00;
logic [7:0] rdata;
logic [7:0] d;
logic [1:0] raw_result = 2'h0;
logic [1:0] remappable_pin, remappable_pin_sel, comparator_on;
logic ladder_on, ladder_pin_enable, ladder_range_select, ladder_source_select, irq, wake;
logic [3:0] ladder_level;
int n_mismatch = 0;
int total_checks = 0;

comparator_output_interrupt dut_u (.ref_clk(ref_clk), .rstn(rstn), .clk_en(clk_en),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .raw_result(raw_result),
    .sleeping(sleeping), .remappable_pin(remappable_pin), .remappable_pin_sel(remappable_pin_sel),
    .comparator_on(comparator_on), .ladder_on(ladder_on), .ladder_pin_enable(ladder_pin_enable),
    .ladder_range_select(ladder_range_select), .ladder_source_select(ladder_source_select),
    .ladder_level(ladder_level), .irq(irq), .wake(wake));

always #5 ref_clk = ~ref_clk;
////////////////////////////////////////////////////////////////////////
task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
        n_mismatch++;
        $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
endtask
task automatic settle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
endtask
task automatic wr_reg(input logic [2:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge ref_clk);
    wr <= 1'b0;
endtask
task automatic rd_reg(input logic [2:0] a, output logic [7:0] v);
    @(posedge ref_clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1 v = rdata;
endtask
// raw path is two flops plus the adjusted register, so six cycles covers it
task automatic set_raw(input logic [1:0] v);
    @(posedge ref_clk);
    raw_result <= v;
    settle(6);
endtask
task automatic do_reset;
    @(posedge ref_clk);
    rstn <= 1'b0;
    repeat (6) @(posedge ref_clk);
    rstn <= 1'b1;
endtask
////////////////////////////////////////////////////////////////////////
task automatic t_reset;
    do_reset();
    rd_reg(CTRL1_ADDR, d);
    chk(d, CTRL_RESET);
    rd_reg(LADDER_ADDR, d);
    chk(d, 8'h00);
    chk({5'h00, comparator_on, ladder_on}, 8'h00);
    set_raw(2'h3);
    rd_reg(FLAGS_ADDR, d);
    chk(d, 8'h00);
    rd_reg(STATUS_ADDR, d);
    chk(d, 8'h00);
    set_raw(2'h0);
endtask
task automatic t_status;
    wr_reg(CTRL1_ADDR, 8'h80);
    wr_reg(CTRL2_ADDR, 8'hA0);
    set_raw(2'h1);
    rd_reg(STATUS_ADDR, d);
    chk(d, 8'h03);
    wr_reg(STATUS_ADDR, 8'hFF);
    set_raw(2'h2);
    rd_reg(STATUS_ADDR, d);
    chk(d, 8'h00);
    wr_reg(CTRL1_ADDR, 8'hC0);
    set_raw(2'h1);
    chk({4'h0, remappable_pin_sel, remappable_pin}, 8'h07);
    chk({6'h00, comparator_on}, 8'h03);
endtask
// mode is changed only from the no-edge setting, so polarity flips raise no flag
task automatic t_edges;
    logic [7:0] c;
    logic up;
    for (int i = 0; i < 8; i++) begin
        c = {2'b10, i[2], i[1:0], 3'b000};
        set_raw(2'h0);
        wr_reg(CTRL1_ADDR, c & 8'hE7);
        settle(6);
        wr_reg(FLAGS_ADDR, 8'h00);
        wr_reg(CTRL1_ADDR, c);
        rd_reg(FLAGS_ADDR, d);
        chk(d, (i[1:0] == 2'h3) ? 8'h20 : 8'h00);
        wr_reg(FLAGS_ADDR, 8'h00);
        up = i[2] ? i[1] : i[0];
        set_raw(2'h1);
        rd_reg(STATUS_ADDR, d);
        chk(d, {6'h00, 1'b1, ~i[2]});
        rd_reg(FLAGS_ADDR, d);
        chk(d, up ? 8'h20 : 8'h00);
        wr_reg(FLAGS_ADDR, 8'h00);
        up = i[2] ? i[0] : i[1];
        set_raw(2'h0);
        rd_reg(FLAGS_ADDR, d);
        chk(d, up ? 8'h20 : 8'h00);
    end
endtask
task automatic t_irq;
    wr_reg(FLAGS_ADDR, 8'h40);
    rd_reg(FLAGS_ADDR, d);
    chk(d, 8'h40);
    wr_reg(ENABLES_ADDR, 8'h40);
    wr_reg(CORE_ADDR, 8'h40);
    settle(2);
    chk({7'h00, irq}, 8'h00);
    wr_reg(CORE_ADDR, 8'hC0);
    settle(2);
    chk({7'h00, irq}, 8'h01);
    wr_reg(CTRL2_ADDR, 8'h20);
    @(posedge ref_clk);
    sleeping <= 1'b1;
    settle(2);
    chk({7'h00, wake}, 8'h01);
    rd_reg(CTRL1_ADDR, d);
    chk(d, 8'hB8);
    @(posedge ref_clk);
    sleeping <= 1'b0;
    rd_reg(FLAGS_ADDR, d);
    chk(d, 8'h40);
    wr_reg(FLAGS_ADDR, 8'h00);
    settle(2);
    chk({6'h00, wake, irq}, 8'h00);
    // a write while frozen must not land
    @(posedge ref_clk);
    clk_en <= 1'b0;
    wr_reg(FLAGS_ADDR, 8'h60);
    clk_en <= 1'b1;
    rd_reg(FLAGS_ADDR, d);
    chk(d, 8'h00);
endtask
task automatic t_ladder;
    wr_reg(LADDER_ADDR, 8'hFA);
    settle(1);
    chk({ladder_on, ladder_pin_enable, ladder_range_select, ladder_source_select,
        ladder_level}, 8'hFA);
    wr_reg(LADDER_ADDR, 8'h05);
    settle(1);
    chk({ladder_on, ladder_pin_enable, ladder_range_select, ladder_source_select,
        ladder_level}, 8'h05);
    do_reset();
    rd_reg(CTRL1_ADDR, d);
    chk(d, CTRL_RESET);
    chk({ladder_on, ladder_pin_enable, ladder_range_select, ladder_source_select,
        ladder_level}, 8'h00);
endtask
////////////////////////////////////////////////////////////////////////
task automatic stop_test;
    $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
        $display("Testbench passed");
    end else begin
        $display("Testbench failed");
    end
    $finish;
endtask
// whole sequence needs about 500 cycles; this leaves wide margin
initial begin
    #200000;
    n_mismatch++;
    stop_test();
end
initial begin
    t_reset();
    t_status();
    t_edges();
    t_irq();
    t_ladder();
    stop_test();
end
endmodule
